// ===== common/pfd_pkg.sv
package pfd_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_DT_CFG      = 8'h00;
  localparam logic [7:0] ADDR_RISE_SHADOW = 8'h04;
  localparam logic [7:0] ADDR_FALL_SHADOW = 8'h08;
  localparam logic [7:0] ADDR_FORCE_CFG   = 8'h0c;
  localparam logic [7:0] ADDR_FORCE_CMD   = 8'h10;
  localparam logic [7:0] ADDR_STATUS      = 8'h14;
  localparam logic [7:0] ADDR_RISE_ACTIVE = 8'h18;
  localparam logic [7:0] ADDR_FALL_ACTIVE = 8'h1c;

  // ----------------------------------------------------------------
  // dead time configuration fields
  // ----------------------------------------------------------------
  localparam int SW_SECOND_BYPASS = 0;
  localparam int SW_FIRST_BYPASS  = 1;
  localparam int SW_RISE_INVERT   = 2;
  localparam int SW_FALL_INVERT   = 3;
  localparam int SW_RISE_SRC_SEL  = 4;
  localparam int SW_FALL_SRC_SEL  = 5;
  localparam int SW_FIRST_SWAP    = 6;
  localparam int SW_SECOND_SWAP   = 7;
  localparam int SW_DUAL_EDGE     = 8;
  localparam int SW_COUNT         = 9;
  localparam int CFG_CLK_SEL      = 9;
  localparam logic [8:0] SW_RESET = 9'h003;

  // ----------------------------------------------------------------
  // force configuration and command fields
  // ----------------------------------------------------------------
  localparam int FC_EN_FIRST       = 0;
  localparam int FC_EN_SECOND      = 1;
  localparam int FC_HELD_LVL_FIRST = 2;
  localparam int FC_HELD_LVL_SEC   = 3;
  localparam int FC_HELD_TRIG_SEL  = 4;
  localparam int FC_ONE_LVL_FIRST  = 5;
  localparam int FC_ONE_LVL_SEC    = 6;
  localparam int FC_WIDTH          = 7;
  localparam logic [6:0] FC_RESET  = 7'h00;
  localparam int CMD_ONESHOT_FIRE  = 0;
  localparam int CMD_HELD_ARM      = 1;
  localparam int CMD_HELD_RELEASE  = 2;

  // ----------------------------------------------------------------
  // status fields
  // ----------------------------------------------------------------
  localparam int ST_OUT_FIRST   = 0;
  localparam int ST_OUT_SECOND  = 1;
  localparam int ST_ONESHOT_LSB = 2;
  localparam int ST_HELD_LSB    = 4;
  localparam int ST_HELD_ARMED  = 6;
  localparam int ST_PENDING     = 7;

  localparam int DLY_WIDTH_DEFAULT = 16;

endpackage

// ===== verilog/pfd_top.sv
// What this block does
// - count-up single edge: first follows B, second A
// - pulse placement: first high for B minus A
// - up-down symmetric: first follows A, second B
// - complementary: second active low, dead time B-A
// - oneshot force acts now, next event overrides
// - held force stays until release; trigger selectable
// - forcing enabled separately per output
// - both outputs derivable from first input
// - delay counts written to shadow registers
// - nine switches route the dead time path
// - every switch combination is accepted
// - both bypass set passes inputs through, swaps still apply
// - bypass 0, rise inv 0, fall inv 1: high complementary
// - bypass 0, rise inv 1, fall inv 0: low complementary
// - bypass 0, inversions 0: both high mode
// - bypass 0, inversions 1: both low mode
// - first bypassed, second is fall-delayed first
// - second bypassed, first is rise-delayed first
// - typical modes: selects, swaps, dual-edge zero
// - independent 16-bit delay counts in delay clocks
// - delay clock is module or timer clock
// - shadow copies load at cycle start event
//
// Decided for this implementation: the placing of the registers and the APB register port.
module pfd_top #(
  parameter int DLY_W = pfd_pkg::DLY_WIDTH_DEFAULT
) (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        gen_in_first,
  input  wire logic        gen_in_second,
  input  wire logic        gen_event_first,
  input  wire logic        gen_event_second,
  input  wire logic        upcount_zero_event,
  input  wire logic        timer_clock,
  output logic             pwm_out_first,
  output logic             pwm_out_second
);

  // ----------------------------------------------------------------
  // parameter check
  // ----------------------------------------------------------------
  if (DLY_W < 1 || DLY_W > 16)
  begin : g_bad_width
    $error("DLY_W must be 1 to 16");
  end

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [8:0]       sw;
    logic             clk_sel;
    logic [DLY_W-1:0] rise_sh;
    logic [DLY_W-1:0] fall_sh;
    logic [DLY_W-1:0] rise_act;
    logic [DLY_W-1:0] fall_act;
    logic             pending;
    logic [6:0]       fcfg;
    logic [1:0]       oneshot_act;
    logic [1:0]       oneshot_lvl;
    logic             held_armed;
    logic [1:0]       held_act;
    logic             frc_first;
    logic             frc_second;
    logic             r_prev;
    logic             r_out;
    logic [DLY_W-1:0] r_cnt;
    logic             f_prev;
    logic             f_out;
    logic [DLY_W-1:0] f_cnt;
    logic             out_first;
    logic             out_second;
    logic             pready;
    logic [31:0]      prdata;
    logic             pslverr;
  } pfd_state_s;

  pfd_state_s st_q;
  pfd_state_s st_d;

  // ----------------------------------------------------------------
  // delay step: the delayed level waits cfg ticks, the other is immediate
  // ----------------------------------------------------------------
  function automatic logic [DLY_W:0] dly_step(
    input logic             src,
    input logic             prev,
    input logic             out,
    input logic [DLY_W-1:0] cnt,
    input logic [DLY_W-1:0] cfg,
    input logic             tick,
    input logic             pol
  );
    logic             o;
    logic [DLY_W-1:0] c;
    o = out;
    c = cnt;
    if (src != prev)
    begin
      if (src == pol)
      begin
        if (cfg == '0)
        begin
          o = src;
          c = '0;
        end
        else
        begin
          c = cfg;
        end
      end
      else
      begin
        o = src;
        c = '0;
      end
    end
    else if (c != '0 && tick)
    begin
      c = c - 1'b1;
      if (c == '0)
      begin
        o = pol;
      end
    end
    return {o, c};
  endfunction

  function automatic logic [31:0] zext(input logic [DLY_W-1:0] v);
    logic [31:0] r;
    r = '0;
    r[DLY_W-1:0] = v;
    return r;
  endfunction

  // ----------------------------------------------------------------
  // combinational next state
  // ----------------------------------------------------------------
  logic             acc;
  logic             wr;
  logic             rd;
  logic             mapped;
  logic             tick;
  logic             held_trig;
  logic             a_in;
  logic             b_in;
  logic             rise_src;
  logic             fall_src;
  logic             rise_val;
  logic             fall_val;
  logic [DLY_W:0]   r_res;
  logic [DLY_W:0]   f_res;
  logic [1:0]       en;
  logic [1:0]       gen_ev;
  logic [1:0]       gen_in;
  logic [1:0]       frc;
  logic [1:0]       held_lvl;

  always_comb
  begin
    st_d     = st_q;
    acc      = psel && penable && st_q.pready;
    wr       = acc && pwrite;
    rd       = acc && !pwrite;
    mapped   = (paddr <= pfd_pkg::ADDR_FALL_ACTIVE) && (paddr[1:0] == 2'b00);
    en       = {st_q.fcfg[pfd_pkg::FC_EN_SECOND], st_q.fcfg[pfd_pkg::FC_EN_FIRST]};
    held_lvl = {st_q.fcfg[pfd_pkg::FC_HELD_LVL_SEC], st_q.fcfg[pfd_pkg::FC_HELD_LVL_FIRST]};
    gen_ev   = {gen_event_second, gen_event_first};
    // raw pair already shaped by compare values
    gen_in   = {gen_in_second, gen_in_first};

    // apb: one wait state, answer registered
    st_d.pready  = psel && penable && !st_q.pready;
    st_d.pslverr = 1'b0;
    if (psel && penable && !st_q.pready)
    begin
      st_d.pslverr = !mapped;
      st_d.prdata  = '0;
      if (!pwrite)
      begin
        case (paddr)
          pfd_pkg::ADDR_DT_CFG:
          begin
            st_d.prdata[8:0] = st_q.sw;
            st_d.prdata[pfd_pkg::CFG_CLK_SEL] = st_q.clk_sel;
          end
          pfd_pkg::ADDR_RISE_SHADOW: st_d.prdata = zext(st_q.rise_sh);
          pfd_pkg::ADDR_FALL_SHADOW: st_d.prdata = zext(st_q.fall_sh);
          pfd_pkg::ADDR_FORCE_CFG:   st_d.prdata[6:0] = st_q.fcfg;
          pfd_pkg::ADDR_STATUS:
          begin
            st_d.prdata[pfd_pkg::ST_OUT_FIRST]  = st_q.out_first;
            st_d.prdata[pfd_pkg::ST_OUT_SECOND] = st_q.out_second;
            st_d.prdata[pfd_pkg::ST_ONESHOT_LSB +: 2] = st_q.oneshot_act;
            st_d.prdata[pfd_pkg::ST_HELD_LSB +: 2]    = st_q.held_act;
            st_d.prdata[pfd_pkg::ST_HELD_ARMED] = st_q.held_armed;
            st_d.prdata[pfd_pkg::ST_PENDING]    = st_q.pending;
          end
          pfd_pkg::ADDR_RISE_ACTIVE: st_d.prdata = zext(st_q.rise_act);
          pfd_pkg::ADDR_FALL_ACTIVE: st_d.prdata = zext(st_q.fall_act);
          default:                   st_d.prdata = '0;
        endcase
      end
    end

    // shadow load at cycle start; a same-cycle write stays pending
    if (upcount_zero_event && st_q.pending)
    begin
      st_d.rise_act = st_q.rise_sh;
      st_d.fall_act = st_q.fall_sh;
      st_d.pending  = 1'b0;
    end

    // register writes
    if (wr)
    begin
      case (paddr)
        pfd_pkg::ADDR_DT_CFG:
        begin
          st_d.sw      = pwdata[8:0];
          st_d.clk_sel = pwdata[pfd_pkg::CFG_CLK_SEL];
        end
        pfd_pkg::ADDR_RISE_SHADOW:
        begin
          st_d.rise_sh = pwdata[DLY_W-1:0];
          st_d.pending = 1'b1;
        end
        pfd_pkg::ADDR_FALL_SHADOW:
        begin
          st_d.fall_sh = pwdata[DLY_W-1:0];
          st_d.pending = 1'b1;
        end
        pfd_pkg::ADDR_FORCE_CFG: st_d.fcfg = pwdata[6:0];
        default:                 st_d.fcfg = st_d.fcfg;
      endcase
    end

    // oneshot force: next generator event on that output ends it
    for (int i = 0; i < 2; i++)
    begin
      if (gen_ev[i])
      begin
        st_d.oneshot_act[i] = 1'b0;
      end
    end
    if (wr && paddr == pfd_pkg::ADDR_FORCE_CMD && pwdata[pfd_pkg::CMD_ONESHOT_FIRE])
    begin
      st_d.oneshot_act = st_d.oneshot_act | en;
      if (en[0])
      begin
        st_d.oneshot_lvl[0] = st_q.fcfg[pfd_pkg::FC_ONE_LVL_FIRST];
      end
      if (en[1])
      begin
        st_d.oneshot_lvl[1] = st_q.fcfg[pfd_pkg::FC_ONE_LVL_SEC];
      end
    end

    // held force: armed, then triggered, then held until release
    held_trig = st_q.fcfg[pfd_pkg::FC_HELD_TRIG_SEL] ? upcount_zero_event : 1'b1;
    if (st_q.held_armed && held_trig)
    begin
      st_d.held_act   = en;
      st_d.held_armed = 1'b0;
    end
    if (wr && paddr == pfd_pkg::ADDR_FORCE_CMD)
    begin
      if (pwdata[pfd_pkg::CMD_HELD_RELEASE])
      begin
        st_d.held_act   = (st_q.held_armed && held_trig) ? en : 2'b00;
        st_d.held_armed = 1'b0;
      end
      if (pwdata[pfd_pkg::CMD_HELD_ARM])
      begin
        st_d.held_armed = 1'b1;
      end
    end

    // force stage; held wins over oneshot, other output runs freely
    for (int i = 0; i < 2; i++)
    begin
      if (st_q.held_act[i])
      begin
        frc[i] = held_lvl[i];
      end
      else if (st_q.oneshot_act[i])
      begin
        frc[i] = st_q.oneshot_lvl[i];
      end
      else
      begin
        frc[i] = gen_in[i];
      end
    end
    st_d.frc_first  = frc[0];
    st_d.frc_second = frc[1];

    // dead time path
    a_in     = st_q.frc_first;
    b_in     = st_q.frc_second;
    tick     = st_q.clk_sel ? timer_clock : 1'b1;
    rise_src = st_q.sw[pfd_pkg::SW_RISE_SRC_SEL] ? b_in : a_in;
    r_res    = dly_step(rise_src, st_q.r_prev, st_q.r_out, st_q.r_cnt,
                        st_q.rise_act, tick, 1'b1);
    st_d.r_prev = rise_src;
    st_d.r_out  = r_res[DLY_W];
    st_d.r_cnt  = r_res[DLY_W-1:0];
    rise_val    = st_q.r_out ^ st_q.sw[pfd_pkg::SW_RISE_INVERT];

    if (st_q.sw[pfd_pkg::SW_DUAL_EDGE])
    begin
      fall_src = rise_val;
    end
    else
    begin
      fall_src = st_q.sw[pfd_pkg::SW_FALL_SRC_SEL] ? b_in : a_in;
    end
    f_res    = dly_step(fall_src, st_q.f_prev, st_q.f_out, st_q.f_cnt,
                        st_q.fall_act, tick, 1'b0);
    st_d.f_prev = fall_src;
    st_d.f_out  = f_res[DLY_W];
    st_d.f_cnt  = f_res[DLY_W-1:0];
    fall_val    = st_q.f_out ^ st_q.sw[pfd_pkg::SW_FALL_INVERT];

    // output selection: bypass and swap
    if (st_q.sw[pfd_pkg::SW_FIRST_BYPASS])
    begin
      st_d.out_first = st_q.sw[pfd_pkg::SW_FIRST_SWAP] ? b_in : a_in;
    end
    else
    begin
      st_d.out_first = rise_val;
    end
    if (st_q.sw[pfd_pkg::SW_SECOND_BYPASS])
    begin
      st_d.out_second = st_q.sw[pfd_pkg::SW_SECOND_SWAP] ? a_in : b_in;
    end
    else
    begin
      st_d.out_second = fall_val;
    end

    if (srst)
    begin
      st_d          = '0;
      st_d.sw       = pfd_pkg::SW_RESET;
      st_d.fcfg     = pfd_pkg::FC_RESET;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    st_q <= st_d;
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pready         = st_q.pready;
  assign prdata         = st_q.prdata;
  assign pslverr        = st_q.pslverr;
  assign pwm_out_first  = st_q.out_first;
  assign pwm_out_second = st_q.out_second;

endmodule

// ===== verification/pfd_top_checker.sv
module pfd_top_checker #(
  parameter int DLY_W = 16
) (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        gen_in_first,
  input wire logic        gen_in_second,
  input wire logic        gen_event_first,
  input wire logic        gen_event_second,
  input wire logic        upcount_zero_event,
  input wire logic        timer_clock,
  input wire logic        pwm_out_first,
  input wire logic        pwm_out_second
);
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------------------------------
  // shadow of the written configuration
  // ----------------------------------------------------------------
  logic [9:0] cfg_q;
  logic [6:0] fc_q;
  logic [2:0] quiet_q;
  logic       wr_ok;
  logic       cmd_wr;
  logic       byp_cfg;
  logic       byp_ok;

  assign wr_ok   = psel && penable && pready && pwrite;
  assign cmd_wr  = wr_ok && paddr == pfd_pkg::ADDR_FORCE_CMD;
  assign byp_cfg = cfg_q == 10'h003;
  assign byp_ok  = byp_cfg && fc_q[1:0] == 2'h0 && quiet_q == 3'h7;

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      cfg_q   <= 10'h003;
      fc_q    <= 7'h00;
      quiet_q <= 3'h0;
    end
    else
    begin
      if (wr_ok && paddr == pfd_pkg::ADDR_DT_CFG)
        cfg_q <= pwdata[9:0];
      if (wr_ok && paddr == pfd_pkg::ADDR_FORCE_CFG)
        fc_q <= pwdata[6:0];
      if (wr_ok)
        quiet_q <= 3'h0;
      else if (quiet_q != 3'h7)
        quiet_q <= quiet_q + 3'h1;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  a_ready_wait: assert property ($rose(penable) && psel |=> pready)
    else $error("pready not after one wait state");
  a_ready_once: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_unmapped: assert property (pready && paddr > 8'h1c |-> pslverr)
    else $error("no error on unmapped address");
  a_err_mapped: assert property (pready && paddr <= 8'h1c && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("error on mapped address");
  a_cfg_readback: assert property (pready && !pwrite && paddr == pfd_pkg::ADDR_DT_CFG
    |-> prdata[9:0] == cfg_q)
    else $error("switch readback wrong");
  a_pass_first: assert property (byp_ok |-> pwm_out_first == $past(gen_in_first, 2))
    else $error("first output not passed through");
  a_pass_second: assert property (byp_ok |-> pwm_out_second == $past(gen_in_second, 2))
    else $error("second output not passed through");
  a_oneshot_now: assert property (cmd_wr && pwdata[0] && fc_q[0] && byp_cfg
    |-> ##[1:4] pwm_out_first == fc_q[5])
    else $error("oneshot force not applied");
  a_held_now: assert property (cmd_wr && pwdata[1] && fc_q[1] && !fc_q[4] && byp_cfg
    |-> ##[1:4] pwm_out_second == fc_q[3])
    else $error("held force not applied");
endmodule

bind pfd_top pfd_top_checker #(.DLY_W(DLY_W)) u_pfd_top_checker (
  .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .gen_in_first(gen_in_first), .gen_in_second(gen_in_second),
  .gen_event_first(gen_event_first), .gen_event_second(gen_event_second),
  .upcount_zero_event(upcount_zero_event), .timer_clock(timer_clock),
  .pwm_out_first(pwm_out_first), .pwm_out_second(pwm_out_second)
);

// ===== verification/pfd_gen_model.sv
module pfd_gen_model (
  input  wire logic clk,
  input  wire logic zero_en,
  output logic      zero_ev,
  output logic      tick
);
  timeunit 1ns;
  timeprecision 1ns;
  // timer side: zero event every 32 cycles when enabled, tick every 4
  logic [7:0] cnt_q = 8'h00;

  always_ff @(posedge clk)
  begin
    cnt_q   <= cnt_q + 8'h01;
    zero_ev <= zero_en && cnt_q[4:0] == 5'h1f;
    tick    <= cnt_q[1:0] == 2'h3;
  end
endmodule

// ===== verification/pfd_top_bench.sv
module pfd_top_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic        g1 = 1'b0;
  logic        g2 = 1'b0;
  logic        e1 = 1'b0;
  logic        e2 = 1'b0;
  logic        ze = 1'b0;
  logic        pready, pslverr, o1, o2, z, tk;
  logic [31:0] prdata;
  int          n_mismatch = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          a0, b0, a1, b1, n;
  logic [8:0]  mcfg [4] = '{9'h008, 9'h004, 9'h000, 9'h00c};
  logic [1:0]  minv [4] = '{2'b10, 2'b01, 2'b00, 2'b11};

  pfd_top #(.DLY_W(16)) u_pfd_top (
    .clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .gen_in_first(g1), .gen_in_second(g2),
    .gen_event_first(e1), .gen_event_second(e2), .upcount_zero_event(z),
    .timer_clock(tk), .pwm_out_first(o1), .pwm_out_second(o2)
  );
  pfd_gen_model u_pfd_gen_model (.clk(clk), .zero_en(ze), .zero_ev(z), .tick(tk));

  initial
  begin
    forever #10 clk = ~clk;
  end

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // access and compare tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [32:0] r);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
    end
    while (pready !== 1'b1);
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask

  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, e);
  endtask

  task automatic lat(input logic v, input logic s, output int k);
    k = 0;
    g1 <= v;
    do
    begin
      @(posedge clk);
      k++;
    end
    while ((s ? o2 : o1) !== v);
  endtask

  task automatic zero_wait();
    ze <= 1'b1;
    while (z !== 1'b1)
    begin
      @(posedge clk);
    end
    ze <= 1'b0;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(pfd_pkg::ADDR_DT_CFG, 33'h003);
    rd(pfd_pkg::ADDR_RISE_SHADOW, 33'h0);
    rd(pfd_pkg::ADDR_FORCE_CFG, 33'h0);
    rd(8'h20, 33'h100000000);
    wr(pfd_pkg::ADDR_RISE_ACTIVE, 32'h5);
    rd(pfd_pkg::ADDR_RISE_ACTIVE, 33'h0);
    g2 <= 1'b1;
    lat(1'b1, 1'b0, n);
    chk(n, 33'h3);
    chk(o2, 33'h1);
    wr(pfd_pkg::ADDR_DT_CFG, 32'h0);
    g1 <= 1'b0;
    repeat (20) @(posedge clk);
    lat(1'b1, 1'b0, a0);
    repeat (20) @(posedge clk);
    lat(1'b0, 1'b1, b0);
    chk(b0, a0);
    wr(pfd_pkg::ADDR_RISE_SHADOW, 32'h3);
    wr(pfd_pkg::ADDR_FALL_SHADOW, 32'h5);
    rd(pfd_pkg::ADDR_RISE_ACTIVE, 33'h0);
    rd(pfd_pkg::ADDR_FALL_SHADOW, 33'h5);
    zero_wait();
    rd(pfd_pkg::ADDR_RISE_ACTIVE, 33'h3);
    rd(pfd_pkg::ADDR_FALL_ACTIVE, 33'h5);
    lat(1'b1, 1'b0, a1);
    repeat (20) @(posedge clk);
    lat(1'b0, 1'b1, b1);
    chk(a1 - a0, 33'h3);
    chk(b1 - b0, 33'h5);
    for (int i = 0; i < 4; i++)
    begin
      wr(pfd_pkg::ADDR_DT_CFG, {23'h0, mcfg[i]});
      for (int v = 0; v < 2; v++)
      begin
        g1 <= v[0];
        repeat (20) @(posedge clk);
        chk({o2, o1}, {31'h0, minv[i][1] ^ v[0], minv[i][0] ^ v[0]});
      end
    end
    wr(pfd_pkg::ADDR_DT_CFG, 32'h002);
    g1 <= 1'b0;
    repeat (20) @(posedge clk);
    lat(1'b1, 1'b0, n);
    chk(n, 33'h3);
    repeat (20) @(posedge clk);
    lat(1'b0, 1'b1, n);
    chk(n, b1);
    wr(pfd_pkg::ADDR_DT_CFG, 32'h001);
    repeat (20) @(posedge clk);
    lat(1'b1, 1'b0, n);
    chk(n, a1);
    g2 <= 1'b0;
    repeat (4) @(posedge clk);
    chk(o2, 33'h0);
    wr(pfd_pkg::ADDR_DT_CFG, 32'h010);
    g1 <= 1'b0;
    g2 <= 1'b1;
    repeat (20) @(posedge clk);
    chk({o2, o1}, 33'h1);
    wr(pfd_pkg::ADDR_DT_CFG, 32'h200);
    g2 <= 1'b0;
    repeat (20) @(posedge clk);
    lat(1'b1, 1'b0, n);
    chk(n - a0 >= 9 && n - a0 <= 12, 33'h1);
    wr(pfd_pkg::ADDR_DT_CFG, 32'h003);
    wr(pfd_pkg::ADDR_FORCE_CFG, 32'h01);
    wr(pfd_pkg::ADDR_FORCE_CMD, 32'h1);
    repeat (4) @(posedge clk);
    chk(o1, 33'h0);
    g2 <= 1'b1;
    repeat (4) @(posedge clk);
    chk(o2, 33'h1);
    e1 <= 1'b1;
    @(posedge clk);
    e1 <= 1'b0;
    repeat (4) @(posedge clk);
    chk(o1, 33'h1);
    wr(pfd_pkg::ADDR_FORCE_CFG, 32'h02);
    wr(pfd_pkg::ADDR_FORCE_CMD, 32'h2);
    repeat (4) @(posedge clk);
    chk(o2, 33'h0);
    e2 <= 1'b1;
    @(posedge clk);
    e2 <= 1'b0;
    repeat (4) @(posedge clk);
    chk(o2, 33'h0);
    wr(pfd_pkg::ADDR_FORCE_CMD, 32'h4);
    repeat (4) @(posedge clk);
    chk(o2, 33'h1);
    wr(pfd_pkg::ADDR_FORCE_CFG, 32'h12);
    wr(pfd_pkg::ADDR_FORCE_CMD, 32'h2);
    repeat (4) @(posedge clk);
    chk(o2, 33'h1);
    zero_wait();
    repeat (4) @(posedge clk);
    chk(o2, 33'h0);
    print_verdict();
  end
endmodule
